// file: hdl/sfi_defines.vh
// register map, field positions and reset values of the sensor fault indicator
`ifndef SFI_DEFINES_VH
`define SFI_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SFI_ADDR_SETUP      8'h00
`define SFI_ADDR_DIAG_EN    8'h04
`define SFI_ADDR_PWM_PERIOD 8'h08
`define SFI_ADDR_FAULT      8'h0c
`define SFI_ADDR_INT_STATUS 8'h10
`define SFI_ADDR_INT_MASK   8'h14
`define SFI_ADDR_OUT_STATE  8'h18

// ----------------------------------------------------------------------
// customer_setup_register fields
// ----------------------------------------------------------------------
`define SFI_SETUP_LOCK      0
`define SFI_SETUP_DIAG_OFF  1
`define SFI_SETUP_LATCH     2
`define SFI_SETUP_OV_OFF    3
`define SFI_SETUP_BAND      7
`define SFI_SETUP_RST       16'h0000
`define SFI_SETUP_MASK      16'hffbf

// ----------------------------------------------------------------------
// diagnostic enable register fields
// ----------------------------------------------------------------------
`define SFI_EN_PWM_VARIANT  0
`define SFI_EN_EEPROM       1
`define SFI_EN_SM           2
`define SFI_EN_ROM          3
`define SFI_EN_ADDER        4
`define SFI_DIAG_EN_RST     5'h00

// ----------------------------------------------------------------------
// fault vector positions
// ----------------------------------------------------------------------
`define SFI_F_EEPROM        0
`define SFI_F_SM            1
`define SFI_F_ROM           2
`define SFI_F_ADDER         3
`define SFI_F_OV            4
`define SFI_F_UV            5
`define SFI_EV_OT           6
`define SFI_EV_SUPPLY       7

// ----------------------------------------------------------------------
// pwm figures
// ----------------------------------------------------------------------
`define SFI_PWM_PERIOD_RST  16'h00c8
`define SFI_DUTY_SELFTEST   7'h5f
`define SFI_DUTY_ADDER      7'h55
`define SFI_DUTY_OV         7'h4b
`define SFI_DUTY_UV         7'h64

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define SFI_RESP_OKAY       2'b00
`define SFI_RESP_SLVERR     2'b10

`endif

// file: hdl/sfi_fault_latch.v
// gathering, enabling and optional latching of diagnostic fault flags
`timescale 1ns/1ps
module sfi_fault_latch (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [5:0] raw_i,
    input  wire [4:0] diag_en_i,
    input  wire       ov_off_i,
    input  wire       latch_i,
    output wire [5:0] fault_o
);
`include "sfi_defines.vh"

    wire [5:0] gated;
    reg  [5:0] held;

    // ------------------------------------------------------------------
    // enable gating
    // ------------------------------------------------------------------
    assign gated[`SFI_F_EEPROM] = raw_i[`SFI_F_EEPROM] & diag_en_i[`SFI_EN_EEPROM];
    assign gated[`SFI_F_SM]     = raw_i[`SFI_F_SM] & diag_en_i[`SFI_EN_SM];
    assign gated[`SFI_F_ROM]    = raw_i[`SFI_F_ROM] & diag_en_i[`SFI_EN_ROM];
    assign gated[`SFI_F_ADDER]  = raw_i[`SFI_F_ADDER] & diag_en_i[`SFI_EN_ADDER];
    assign gated[`SFI_F_OV]     = raw_i[`SFI_F_OV] & ~ov_off_i;
    // undervoltage supervision cannot be switched off
    assign gated[`SFI_F_UV]     = raw_i[`SFI_F_UV];

    // ------------------------------------------------------------------
    // latch until power-on reset
    // ------------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            held <= 6'h00;
        end else if (latch_i) begin
            held <= held | gated;
        end else begin
            held <= 6'h00;
        end
    end

    // raw path is combinational so a fault shows in its own cycle
    assign fault_o = gated | (held & {6{latch_i}});

endmodule

// file: hdl/sfi_pwm_gen.v
// pwm generator taking period and high time at each period boundary
`timescale 1ns/1ps
module sfi_pwm_gen #(
    parameter PER_W = 17
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [PER_W-1:0] period_i,
    input  wire [PER_W-1:0] high_i,
    output reg              level_o
);

    reg [PER_W-1:0] cnt;
    reg [PER_W-1:0] cur_per;
    reg [PER_W-1:0] cur_hi;

    wire last = (cnt >= cur_per - {{(PER_W-1){1'b0}}, 1'b1});

    // new settings wait for the period end so no runt pulse appears
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt     <= {PER_W{1'b0}};
            cur_per <= {{(PER_W-1){1'b0}}, 1'b1};
            cur_hi  <= {PER_W{1'b0}};
            level_o <= 1'b0;
        end else begin
            if (last) begin
                cnt     <= {PER_W{1'b0}};
                cur_per <= (period_i == {PER_W{1'b0}}) ?
                           {{(PER_W-1){1'b0}}, 1'b1} : period_i;
                cur_hi  <= high_i;
                level_o <= (high_i != {PER_W{1'b0}});
            end else begin
                cnt     <= cnt + {{(PER_W-1){1'b0}}, 1'b1};
                level_o <= (cnt + {{(PER_W-1){1'b0}}, 1'b1}) < cur_hi;
            end
        end
    end

endmodule

// file: hdl/sfi_top.v
// sensor fault indicator: fault gathering, error band and pwm error coding
`timescale 1ns/1ps
module sfi_top #(
    parameter ADDR_W = 8,
    parameter PER_W  = 16,
    parameter CODE_W = 12
) (
    input  wire              CORE_CLK_I,
    input  wire              RESET_I,
    input  wire [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire              S_AXI_AWVALID,
    output wire              S_AXI_AWREADY,
    input  wire [31:0]       S_AXI_WDATA,
    input  wire [3:0]        S_AXI_WSTRB,
    input  wire              S_AXI_WVALID,
    output wire              S_AXI_WREADY,
    output reg  [1:0]        S_AXI_BRESP,
    output reg               S_AXI_BVALID,
    input  wire              S_AXI_BREADY,
    input  wire [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire              S_AXI_ARVALID,
    output wire              S_AXI_ARREADY,
    output reg  [31:0]       S_AXI_RDATA,
    output reg  [1:0]        S_AXI_RRESP,
    output reg               S_AXI_RVALID,
    input  wire              S_AXI_RREADY,
    input  wire              EEPROM_FAIL_I,
    input  wire              SM_FAIL_I,
    input  wire              ROM_PARITY_ERR_I,
    input  wire              ADDER_OVF_I,
    input  wire              OVERVOLT_I,
    input  wire              UNDERVOLT_I,
    input  wire              OVERTEMP_I,
    input  wire              SUPPLY_BREAK_I,
    input  wire [CODE_W-1:0] SENSOR_CODE_I,
    output reg               OUT_O,
    output reg               OUT_OE_O,
    output reg  [CODE_W-1:0] ANA_CODE_O,
    output wire              IRQ_O
);
`include "sfi_defines.vh"

    localparam P1 = PER_W + 1;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function [31:0] merge_strb;
        input [31:0] old;
        input [31:0] wdat;
        input [3:0]  strb;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                merge_strb[i*8 +: 8] = strb[i] ? wdat[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    function [P1-1:0] pct_of;
        input [P1-1:0] per;
        input [6:0]    pct;
        reg   [P1+6:0] prod;
        begin
            prod   = per * pct / 7'h64;
            pct_of = prod[P1-1:0];
        end
    endfunction

    function is_mapped;
        input [ADDR_W-1:0] a;
        begin
            if (a == `SFI_ADDR_SETUP) is_mapped = 1'b1;
            else if (a == `SFI_ADDR_DIAG_EN) is_mapped = 1'b1;
            else if (a == `SFI_ADDR_PWM_PERIOD) is_mapped = 1'b1;
            else if (a == `SFI_ADDR_FAULT) is_mapped = 1'b1;
            else if (a == `SFI_ADDR_INT_STATUS) is_mapped = 1'b1;
            else if (a == `SFI_ADDR_INT_MASK) is_mapped = 1'b1;
            else if (a == `SFI_ADDR_OUT_STATE) is_mapped = 1'b1;
            else is_mapped = 1'b0;
        end
    endfunction

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    reg              aw_held;
    reg [ADDR_W-1:0] aw_addr;
    reg              w_held;
    reg [31:0]       w_data;
    reg [3:0]        w_strb;

    wire wr_go = aw_held & w_held;

    assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
    assign S_AXI_WREADY  = ~w_held & ~S_AXI_BVALID;

    always @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            aw_held      <= 1'b0;
            aw_addr      <= {ADDR_W{1'b0}};
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `SFI_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= is_mapped(aw_addr) ? `SFI_RESP_OKAY : `SFI_RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg  [15:0]      setup;
    reg  [4:0]       diag_en;
    reg  [PER_W-1:0] pwm_base;
    reg  [7:0]       int_status;
    reg  [7:0]       int_mask;
    reg  [7:0]       prev_flags;
    wire [5:0]       fault;
    wire [7:0]       flags = {SUPPLY_BREAK_I, OVERTEMP_I, fault};
    wire [7:0]       events = flags & ~prev_flags;
    wire [31:0]      wmerged_setup = merge_strb({16'h0000, setup}, w_data, w_strb);
    wire [31:0]      wmerged_en = merge_strb({27'h0, diag_en}, w_data, w_strb);
    wire [31:0]      wmerged_per = merge_strb({{(32-PER_W){1'b0}}, pwm_base}, w_data, w_strb);
    wire [31:0]      wmerged_mask = merge_strb({24'h0, int_mask}, w_data, w_strb);
    wire [7:0]       w1c = (wr_go && aw_addr == `SFI_ADDR_INT_STATUS && w_strb[0]) ?
                           w_data[7:0] : 8'h00;

    always @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            setup      <= `SFI_SETUP_RST;
            diag_en    <= `SFI_DIAG_EN_RST;
            pwm_base   <= `SFI_PWM_PERIOD_RST;
            int_mask   <= 8'h00;
            int_status <= 8'h00;
            prev_flags <= 8'h00;
        end else begin
            prev_flags <= flags;
            // a new event in the clearing cycle stays set
            int_status <= (int_status & ~w1c) | events;
            if (wr_go) begin
                if (aw_addr == `SFI_ADDR_SETUP) begin
                    setup <= wmerged_setup[15:0] & `SFI_SETUP_MASK;
                end else if (aw_addr == `SFI_ADDR_DIAG_EN) begin
                    diag_en <= wmerged_en[4:0];
                end else if (aw_addr == `SFI_ADDR_PWM_PERIOD) begin
                    pwm_base <= wmerged_per[PER_W-1:0];
                end else if (aw_addr == `SFI_ADDR_INT_MASK) begin
                    int_mask <= wmerged_mask[7:0];
                end
            end
        end
    end

    assign IRQ_O = |(int_status & int_mask);

    // ------------------------------------------------------------------
    // fault gathering
    // ------------------------------------------------------------------
    sfi_fault_latch u_latch (
        .clk_i     (CORE_CLK_I),
        .rst_i     (RESET_I),
        .raw_i     ({UNDERVOLT_I, OVERVOLT_I, ADDER_OVF_I,
                     ROM_PARITY_ERR_I, SM_FAIL_I, EEPROM_FAIL_I}),
        .diag_en_i (diag_en),
        .ov_off_i  (setup[`SFI_SETUP_OV_OFF]),
        .latch_i   (setup[`SFI_SETUP_LATCH]),
        .fault_o   (fault)
    );

    // ------------------------------------------------------------------
    // error decision
    // ------------------------------------------------------------------
    wire locked    = setup[`SFI_SETUP_LOCK];
    wire pwm_mode  = diag_en[`SFI_EN_PWM_VARIANT];
    wire diag_hit  = |fault[`SFI_F_OV:`SFI_F_EEPROM];
    // undervoltage belongs to the always-active group
    wire err_ind   = (diag_hit & ~setup[`SFI_SETUP_DIAG_OFF]) | fault[`SFI_F_UV];
    // the band bit only counts once the memory is locked
    wire band_low  = locked & setup[`SFI_SETUP_BAND];
    wire pwm_inv   = locked & setup[`SFI_SETUP_BAND];

    reg [6:0] err_pct;
    always @* begin
        // one code only, highest priority first
        if (fault[`SFI_F_UV]) begin
            err_pct = `SFI_DUTY_UV;
        end else if (fault[`SFI_F_EEPROM] | fault[`SFI_F_SM] | fault[`SFI_F_ROM]) begin
            err_pct = `SFI_DUTY_SELFTEST;
        end else if (fault[`SFI_F_ADDER]) begin
            err_pct = `SFI_DUTY_ADDER;
        end else begin
            err_pct = `SFI_DUTY_OV;
        end
    end

    // ------------------------------------------------------------------
    // pwm period and high time
    // ------------------------------------------------------------------
    wire [P1-1:0]        per_eff = err_ind ? {pwm_base, 1'b0} : {1'b0, pwm_base};
    wire [P1+CODE_W-1:0] norm_prod = per_eff * SENSOR_CODE_I;
    wire [P1-1:0]        hi_norm = norm_prod[P1+CODE_W-1:CODE_W];
    wire [P1-1:0]        hi_eff = err_ind ? pct_of(per_eff, err_pct) : hi_norm;
    wire                 pwm_level;

    sfi_pwm_gen #(
        .PER_W (P1)
    ) u_pwm (
        .clk_i    (CORE_CLK_I),
        .rst_i    (RESET_I),
        .period_i (per_eff),
        .high_i   (hi_eff),
        .level_o  (pwm_level)
    );

    // ------------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------------
    always @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            OUT_O      <= 1'b0;
            OUT_OE_O   <= 1'b0;
            ANA_CODE_O <= {CODE_W{1'b0}};
        end else if (SUPPLY_BREAK_I) begin
            OUT_O      <= 1'b0;
            OUT_OE_O   <= 1'b1;
            ANA_CODE_O <= {CODE_W{1'b0}};
        end else if (OVERTEMP_I) begin
            OUT_O      <= 1'b0;
            OUT_OE_O   <= 1'b0;
            ANA_CODE_O <= {CODE_W{1'b0}};
        end else if (pwm_mode) begin
            OUT_O      <= pwm_level ^ pwm_inv;
            OUT_OE_O   <= 1'b1;
            ANA_CODE_O <= {CODE_W{1'b0}};
        end else if (err_ind) begin
            OUT_O      <= ~band_low;
            OUT_OE_O   <= 1'b1;
            ANA_CODE_O <= band_low ? {CODE_W{1'b0}} : {CODE_W{1'b1}};
        end else begin
            OUT_O      <= 1'b0;
            OUT_OE_O   <= 1'b1;
            ANA_CODE_O <= SENSOR_CODE_I;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    reg [31:0] rd_word;
    always @* begin
        if (S_AXI_ARADDR == `SFI_ADDR_SETUP) begin
            rd_word = {16'h0000, setup};
        end else if (S_AXI_ARADDR == `SFI_ADDR_DIAG_EN) begin
            rd_word = {27'h0, diag_en};
        end else if (S_AXI_ARADDR == `SFI_ADDR_PWM_PERIOD) begin
            rd_word = {{(32-PER_W){1'b0}}, pwm_base};
        end else if (S_AXI_ARADDR == `SFI_ADDR_FAULT) begin
            rd_word = {24'h0, flags};
        end else if (S_AXI_ARADDR == `SFI_ADDR_INT_STATUS) begin
            rd_word = {24'h0, int_status};
        end else if (S_AXI_ARADDR == `SFI_ADDR_INT_MASK) begin
            rd_word = {24'h0, int_mask};
        end else if (S_AXI_ARADDR == `SFI_ADDR_OUT_STATE) begin
            rd_word = {27'h0, band_low, err_ind, pwm_mode, OUT_OE_O, OUT_O};
        end else begin
            rd_word = 32'h0000_0000;
        end
    end

    assign S_AXI_ARREADY = ~S_AXI_RVALID;

    always @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= `SFI_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_word;
            S_AXI_RRESP  <= is_mapped(S_AXI_ARADDR) ? `SFI_RESP_OKAY : `SFI_RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

endmodule

// file: bench/sfi_top_asserts.sv
// assertion checker bound to the sensor fault indicator top
`timescale 1ns/1ps
module sfi_top_asserts #(
    parameter CODE_W = 12
) (
    input wire              CORE_CLK_I,
    input wire              RESET_I,
    input wire              S_AXI_AWVALID,
    input wire              S_AXI_AWREADY,
    input wire              S_AXI_WVALID,
    input wire              S_AXI_WREADY,
    input wire              S_AXI_BVALID,
    input wire              S_AXI_BREADY,
    input wire              S_AXI_ARVALID,
    input wire              S_AXI_ARREADY,
    input wire              S_AXI_RVALID,
    input wire              S_AXI_RREADY,
    input wire              OVERTEMP_I,
    input wire              SUPPLY_BREAK_I,
    input wire              OUT_O,
    input wire              OUT_OE_O,
    input wire [CODE_W-1:0] ANA_CODE_O
);
    default clocking dc @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);

    property p_tri;
        OVERTEMP_I && !SUPPLY_BREAK_I |=> !OUT_OE_O;
    endproperty
    a_tri: assert property (p_tri) else $error("driver kept on in over-temperature");
    property p_oe_on;
        !OVERTEMP_I |=> OUT_OE_O;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("driver off without cause");
    property p_sup;
        SUPPLY_BREAK_I |=> OUT_OE_O && !OUT_O && ANA_CODE_O == 0;
    endproperty
    a_sup: assert property (p_sup) else $error("pin not grounded on supply break");
    property p_wbusy;
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
    endproperty
    a_wbusy: assert property (p_wbusy) else $error("write taken while response pending");
    property p_arrdy;
        S_AXI_ARREADY != S_AXI_RVALID;
    endproperty
    a_arrdy: assert property (p_arrdy) else $error("read ready wrong");
    property p_wresp;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID;
    endproperty
    a_wresp: assert property (p_wresp) else $error("write response late");
    property p_rresp;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
    endproperty
    a_rresp: assert property (p_rresp) else $error("read data late");
    property p_bclr;
        S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
    endproperty
    a_bclr: assert property (p_bclr) else $error("write response repeated");
    property p_rclr;
        S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
    endproperty
    a_rclr: assert property (p_rclr) else $error("read data repeated");
endmodule

bind sfi_top sfi_top_asserts #(.CODE_W(CODE_W)) sfi_top_asserts_inst (.*);

// file: bench/sfi_pwm_rx.sv
// behavioural receiver measuring period and high time of the output pin
`timescale 1ns/1ps
module sfi_pwm_rx (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        out_i,
    input  wire        oe_i,
    output reg  [16:0] period_o,
    output reg  [16:0] high_o
);
    // external pull-up holds the line high while the driver is off
    wire       lvl = oe_i ? out_i : 1'b1;
    reg        prev;
    reg [16:0] cnt;
    reg [16:0] hcnt;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev <= 1'b1;
            cnt <= 17'h00000;
            hcnt <= 17'h00000;
            period_o <= 17'h00000;
            high_o <= 17'h00000;
        end else begin
            prev <= lvl;
            if (lvl && !prev) begin
                period_o <= cnt;
                high_o <= hcnt;
                cnt <= 17'h00001;
                hcnt <= 17'h00001;
            end else begin
                cnt <= cnt + 17'h00001;
                hcnt <= hcnt + {16'h0000, lvl};
            end
        end
    end
endmodule

// file: bench/sfi_top_tb.sv
// self-checking testbench of the sensor fault indicator
`timescale 1ns/1ps
`include "sfi_defines.vh"
module sfi_top_tb;
    typedef struct packed {
        logic [15:0] setup;
        logic [4:0]  en;
        logic [7:0]  flt;
        logic [11:0] ana;
        logic        out;
        logic        oe;
        logic [7:0]  per;
        logic [7:0]  hi;
    } sfi_row_t;
    logic        CORE_CLK_I = 1'b0;
    logic        RESET_I = 1'b1;
    logic [7:0]  S_AXI_AWADDR = 8'h00;
    logic [7:0]  S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0;
    logic [3:0]  S_AXI_WSTRB = 4'hf;
    logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic [11:0] SENSOR_CODE_I = 12'h800;
    logic [7:0]  flt = 8'h00;
    logic [31:0] got;
    logic [1:0]  resp;
    int          fail_count = 0, checks_done = 0, cycles = 0, n;
    sfi_row_t    r;
    wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    wire         OUT_O, OUT_OE_O, IRQ_O;
    wire [1:0]   S_AXI_BRESP, S_AXI_RRESP;
    wire [31:0]  S_AXI_RDATA;
    wire [11:0]  ANA_CODE_O;
    wire [16:0]  meas_per, meas_hi;
    wire         EEPROM_FAIL_I, SM_FAIL_I, ROM_PARITY_ERR_I, ADDER_OVF_I;
    wire         OVERVOLT_I, UNDERVOLT_I, OVERTEMP_I, SUPPLY_BREAK_I;
    assign {SUPPLY_BREAK_I, OVERTEMP_I, UNDERVOLT_I, OVERVOLT_I, ADDER_OVF_I,
            ROM_PARITY_ERR_I, SM_FAIL_I, EEPROM_FAIL_I} = flt;
    // setup, enables, faults, code, pin, enable, pwm period, pwm high
    sfi_row_t rows [0:15] = '{
        '{0, 0, 0, 12'h800, 0, 1, 0, 0},
        '{0, 0, 8'h10, 12'hfff, 1, 1, 0, 0},
        '{8, 0, 8'h10, 12'h800, 0, 1, 0, 0},
        '{0, 8, 4, 12'hfff, 1, 1, 0, 0},
        '{0, 0, 4, 12'h800, 0, 1, 0, 0},
        '{2, 5'h1e, 8'h0f, 12'h800, 0, 1, 0, 0},
        '{2, 0, 8'h20, 12'hfff, 1, 1, 0, 0},
        '{16'h80, 4, 2, 12'hfff, 1, 1, 0, 0},
        '{0, 0, 8'h40, 0, 0, 0, 0, 0},
        '{0, 0, 8'hc0, 0, 0, 1, 0, 0},
        '{0, 5'h1f, 0, 0, 0, 1, 20, 10},
        '{0, 5'h1f, 1, 0, 0, 1, 40, 38},
        '{0, 5'h1f, 2, 0, 0, 1, 40, 38},
        '{0, 5'h1f, 8, 0, 0, 1, 40, 34},
        '{0, 5'h1f, 8'h10, 0, 0, 1, 40, 30},
        '{0, 5'h1f, 8'h18, 0, 0, 1, 40, 34}};

    sfi_top sfi_top_inst (.*);
    sfi_pwm_rx sfi_pwm_rx_inst (.clk_i(CORE_CLK_I), .rst_i(RESET_I), .out_i(OUT_O),
                                .oe_i(OUT_OE_O), .period_o(meas_per), .high_o(meas_hi));

    initial forever #2.5 CORE_CLK_I = ~CORE_CLK_I;

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // hang guard: the whole run needs well under half of this
    always @(posedge CORE_CLK_I) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            end_of_test;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, m, g, e);
        end
    endtask

    // each transfer starts one edge later so ready strobes never toggle twice a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK_I);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK_I);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (!S_AXI_BVALID);
        resp = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        @(posedge CORE_CLK_I);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge CORE_CLK_I);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (!S_AXI_RVALID);
        got = S_AXI_RDATA;
        resp = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
        chk(got, e, m);
    endtask

    initial begin
        repeat (20) @(posedge CORE_CLK_I);
        RESET_I <= 1'b0;
        rd(`SFI_ADDR_SETUP, 0, "setup reset");
        rd(`SFI_ADDR_DIAG_EN, 0, "enable reset");
        rd(`SFI_ADDR_PWM_PERIOD, 32'h00c8, "period reset");
        rd(`SFI_ADDR_INT_MASK, 0, "mask reset");
        wr(`SFI_ADDR_SETUP, 32'h40);
        rd(`SFI_ADDR_SETUP, 0, "reserved setup bit");
        wr(8'h1c, 32'h1);
        chk(resp, `SFI_RESP_SLVERR, "unmapped write");
        rd(8'h1c, 0, "unmapped read");
        chk(resp, `SFI_RESP_SLVERR, "unmapped read answer");
        S_AXI_WSTRB <= 4'h1;
        wr(`SFI_ADDR_PWM_PERIOD, 32'h0000ab14);
        S_AXI_WSTRB <= 4'hf;
        rd(`SFI_ADDR_PWM_PERIOD, 32'h14, "byte lane write");
        $display("end of test registers");
        for (int i = 0; i < 16; i++) begin
            r = rows[i];
            @(posedge CORE_CLK_I) flt <= 8'h00;
            wr(`SFI_ADDR_SETUP, {16'h0000, r.setup});
            wr(`SFI_ADDR_DIAG_EN, {27'h0, r.en});
            flt <= r.flt;
            @(posedge CORE_CLK_I);
            #1;
            chk(OUT_OE_O, r.oe, "driver enable");
            if (r.oe && r.per == 0) begin
                chk(ANA_CODE_O, r.ana, "analog code");
                chk(OUT_O, r.out, "pin level");
            end
            if (r.per != 0) begin
                repeat (150) @(posedge CORE_CLK_I);
                chk(meas_per, r.per, "pwm period");
                chk(meas_hi, r.hi, "pwm high time");
            end
            $display("end of test row %0d", i);
        end
        flt <= 8'h20;
        repeat (150) @(posedge CORE_CLK_I);
        n = 0;
        repeat (80) begin
            @(posedge CORE_CLK_I);
            n += OUT_O;
        end
        chk(n, 80, "undervoltage constant high");
        flt <= 8'h00;
        wr(`SFI_ADDR_DIAG_EN, 0);
        wr(`SFI_ADDR_INT_STATUS, 32'hff);
        wr(`SFI_ADDR_INT_MASK, 32'h10);
        flt <= 8'h10;
        repeat (3) @(posedge CORE_CLK_I);
        flt <= 8'h00;
        repeat (3) @(posedge CORE_CLK_I);
        chk(IRQ_O, 1, "sticky interrupt");
        rd(`SFI_ADDR_INT_STATUS, 32'h10, "interrupt status");
        wr(`SFI_ADDR_INT_STATUS, 32'h10);
        @(posedge CORE_CLK_I);
        chk(IRQ_O, 0, "interrupt cleared");
        wr(`SFI_ADDR_INT_MASK, 0);
        flt <= 8'h10;
        repeat (3) @(posedge CORE_CLK_I);
        chk(IRQ_O, 0, "masked interrupt");
        rd(`SFI_ADDR_INT_STATUS, 32'h10, "masked status");
        $display("end of test interrupt");
        flt <= 8'h00;
        wr(`SFI_ADDR_SETUP, 32'h04);
        wr(`SFI_ADDR_DIAG_EN, 32'h02);
        flt <= 8'h01;
        repeat (2) @(posedge CORE_CLK_I);
        flt <= 8'h00;
        repeat (3) @(posedge CORE_CLK_I);
        rd(`SFI_ADDR_FAULT, 32'h01, "latched fault");
        chk(ANA_CODE_O, 12'hfff, "latched band");
        RESET_I <= 1'b1;
        repeat (3) @(posedge CORE_CLK_I);
        RESET_I <= 1'b0;
        rd(`SFI_ADDR_FAULT, 0, "fault after reset");
        $display("end of test latch");
        wr(`SFI_ADDR_SETUP, 32'h81);
        flt <= 8'h10;
        @(posedge CORE_CLK_I);
        #1;
        chk(ANA_CODE_O, 0, "low band code");
        chk(OUT_O, 0, "low band pin");
        rd(`SFI_ADDR_OUT_STATE, 32'h1a, "output state");
        $display("end of test locked band");
        end_of_test;
    end
endmodule
